// ===== rtl/sms_lock_det.sv
// Lock detector: counts sync markers and drops lock after a silent gap.
// Assumes mark_i is a one-cycle pulse per marker and clear_i restarts the hunt.
`timescale 1ns/1ps
module sms_lock_det #(
    parameter int HITS    = sms_pkg::LOCK_HITS,
    parameter int TIMEOUT = sms_pkg::LOCK_TIMEOUT
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic clear_i,
    input  wire logic mark_i,
    // Status
    output logic      locked_o
);

    localparam int GAP_W = $clog2(TIMEOUT + 1);
    localparam int HIT_W = $clog2(HITS + 1);

    logic [GAP_W-1:0] gap;
    logic [HIT_W-1:0] hits;
    logic             timed_out;

    assign timed_out = (gap == GAP_W'(TIMEOUT));

    // Gap since the last marker
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i || mark_i)
            gap <= '0;
        else if (!timed_out)
            gap <= gap + GAP_W'(1);
    end

    // Marker count and lock flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i || timed_out)
        begin
            hits     <= '0;
            locked_o <= 1'b0;
        end
        else if (mark_i)
        begin
            if (hits != HIT_W'(HITS))
                hits <= hits + HIT_W'(1);
            if (hits >= HIT_W'(HITS - 1))
                locked_o <= 1'b1;
        end
    end

    // Lock never survives a full silent gap
    chk_lock_gap_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        timed_out |=> !locked_o)
        else $error("lock held after silent gap");

endmodule : sms_lock_det

// ===== rtl/sms_pkg.sv
// Shared constants for the serializer mode select and lock block.
// Assumes one parallel clock domain and a plain strobe register port.
package sms_pkg;

    // Parallel bus widths
    localparam int DATA_W = 20;
    localparam int HALF_W = 10;

    // Operating modes, one-hot
    typedef enum logic [3:0] {
        SMS_MODE_NONE  = 4'b0001,
        SMS_MODE_VIDEO = 4'b0010,
        SMS_MODE_THRU  = 4'b0100,
        SMS_MODE_ASI   = 4'b1000
    } sms_mode_e;

    // Register map, byte offsets
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h4;
    localparam logic [3:0]  ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0]  ADDR_IRQ_MASK = 4'hc;

    // Control and status fields
    localparam int          CTRL_DET_EN   = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int          ST_LOCK       = 0;
    localparam int          ST_WIDTH20    = 1;
    localparam int          ST_SD         = 2;
    localparam int          ST_MODE_LSB   = 3;

    // Interrupt bits
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_LOCK_GAIN = 0;
    localparam int          IRQ_LOCK_LOSS = 1;
    localparam int          IRQ_MODE_CHG  = 2;

    // Serial rates in kbit/s; the HD rate may also run divided by 1.001
    localparam int          RATE_W        = 21;
    localparam logic [20:0] HD_RATE_KBPS  = 21'd1485000;
    localparam logic [20:0] SD_RATE_KBPS  = 21'd270000;

    // Sync markers seen on the upper half of the bus
    localparam logic [9:0]  TRS_ONES      = 10'h3ff;
    localparam logic [9:0]  TRS_ZERO      = 10'h000;
    localparam logic [9:0]  COMMA_NEG     = 10'h0fa;
    localparam logic [9:0]  COMMA_POS     = 10'h305;

    // Lock detection defaults
    localparam int          LOCK_HITS     = 3;
    localparam int          LOCK_TIMEOUT  = 8192;

endpackage : sms_pkg

// ===== rtl/sms_sync.sv
// Two-flop synchroniser bank for the static select inputs.
// Assumes the inputs are slow levels with no timing relation to clk_i.
`timescale 1ns/1ps
module sms_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // Two flops per bit; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    meta[g]   <= 1'b0;
                    sync_o[g] <= 1'b0;
                end
                else
                begin
                    meta[g]   <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule : sms_sync

// ===== rtl/sms_top.sv
// Mode selection and lock status of a multi-rate video serializer front end.
// Assumes clk_i is the parallel clock and the selects are static, unsynchronised levels.
// Operation
// - Async-serial mode only with async select high, rate high, video select low.
// - Async select low means no async-serial encoding of incoming data.
// - Lock high when locked to compliant data in the current mode, else low.
// - Rate select low configures only the HD rate, or HD rate over 1.001.
// - Rate select high configures only the SD rate of 270 Mb/s.
// - Width select matters only in video and data-through modes.
// - Width select high takes the parallel input as 20-bit words.
// - Width select low takes the parallel input as 10-bit multiplexed words.
// - Video mode when video select high and async select low.
// - Data-through mode when video select and async select both low.
`timescale 1ns/1ps
module sms_top #(
    parameter int LOCK_HITS    = sms_pkg::LOCK_HITS,
    parameter int LOCK_TIMEOUT = sms_pkg::LOCK_TIMEOUT
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Static selects
    input  wire logic                       async_serial_mode_select_i,
    input  wire logic                       line_rate_select_i,
    input  wire logic                       bus_width_select_i,
    input  wire logic                       video_processing_select_i,
    // Parallel input
    input  wire logic [sms_pkg::DATA_W-1:0] din_i,
    // Parallel output to the encoder
    output logic      [sms_pkg::DATA_W-1:0] par_data_o,
    output logic                            par_valid_o,
    // Mode controls
    output logic      [3:0]                 mode_o,
    output logic                            asi_encode_en_o,
    output logic                            width_20_o,
    output logic                            sd_rate_o,
    output logic      [sms_pkg::RATE_W-1:0] serial_rate_kbps_o,
    // Lock status
    output logic                            locked_o,
    // Register port
    input  wire logic [sms_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [31:0]                reg_rdata_o,
    // Interrupt
    output logic                            irq_o
);

    localparam int SEL_ASI  = 0;
    localparam int SEL_RATE = 1;
    localparam int SEL_WID  = 2;
    localparam int SEL_VID  = 3;

    logic [3:0]                 sel_raw;
    logic [3:0]                 sel;
    sms_pkg::sms_mode_e         mode;
    sms_pkg::sms_mode_e         next_mode;
    logic                       width_20;
    logic                       sd_rate;
    logic                       phase;
    logic [sms_pkg::HALF_W-1:0] hist0;
    logic [sms_pkg::HALF_W-1:0] hist1;
    logic                       mark;
    logic                       det_clear;
    logic                       det_locked;
    logic                       locked_d;
    logic                       mode_chg;
    logic [31:0]                ctrl;
    logic [sms_pkg::IRQ_W-1:0]  irq_stat;
    logic [sms_pkg::IRQ_W-1:0]  irq_mask;
    logic [sms_pkg::IRQ_W-1:0]  irq_evt;

    // Upper half of the bus carries the 10-bit word in every narrow mode
    function automatic logic [sms_pkg::HALF_W-1:0] upper_half(input logic [sms_pkg::DATA_W-1:0] w);
        upper_half = w[sms_pkg::DATA_W-1:sms_pkg::HALF_W];
    endfunction : upper_half

    // Decode of the synchronised selects into a mode
    function automatic sms_pkg::sms_mode_e decode_mode(input logic [3:0] s);
        if (s[SEL_ASI] && s[SEL_RATE] && !s[SEL_VID])
            decode_mode = sms_pkg::SMS_MODE_ASI;
        else if (s[SEL_VID] && !s[SEL_ASI])
            decode_mode = sms_pkg::SMS_MODE_VIDEO;
        else if (!s[SEL_VID] && !s[SEL_ASI])
            decode_mode = sms_pkg::SMS_MODE_THRU;
        else
            decode_mode = sms_pkg::SMS_MODE_NONE;
    endfunction : decode_mode

    // Selects into the parallel clock domain
    assign sel_raw = {video_processing_select_i, bus_width_select_i,
                      line_rate_select_i, async_serial_mode_select_i};

    sms_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (sel_raw),
        .sync_o  (sel)
    );

    assign next_mode = decode_mode(sel);

    // Mode, rate and width registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode     <= sms_pkg::SMS_MODE_NONE;
            width_20 <= 1'b0;
            sd_rate  <= 1'b0;
        end
        else
        begin
            mode     <= next_mode;
            width_20 <= sel[SEL_WID];
            sd_rate  <= sel[SEL_RATE];
        end
    end

    assign mode_chg = (next_mode != mode);

    // Mode controls seen by the encoder and serializer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            asi_encode_en_o    <= 1'b0;
            serial_rate_kbps_o <= sms_pkg::HD_RATE_KBPS;
        end
        else
        begin
            asi_encode_en_o    <= (next_mode == sms_pkg::SMS_MODE_ASI);
            serial_rate_kbps_o <= sel[SEL_RATE] ? sms_pkg::SD_RATE_KBPS
                                                : sms_pkg::HD_RATE_KBPS;
        end
    end

    assign mode_o     = mode;
    assign width_20_o = width_20;
    assign sd_rate_o  = sd_rate;

    // Pairing phase for 10-bit multiplexed input
    always_ff @(posedge clk_i)
    begin
        if (rst_i || mode_chg)
            phase <= 1'b0;
        else if (mode != sms_pkg::SMS_MODE_ASI && !width_20)
            phase <= ~phase;
        else
            phase <= 1'b0;
    end

    // Parallel word assembly per mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            par_data_o  <= '0;
            par_valid_o <= 1'b0;
        end
        else
        begin
            par_valid_o <= 1'b0;
            case (mode)
                sms_pkg::SMS_MODE_ASI:
                begin
                    par_data_o  <= {{sms_pkg::HALF_W{1'b0}}, upper_half(din_i)};
                    par_valid_o <= 1'b1;
                end
                sms_pkg::SMS_MODE_VIDEO, sms_pkg::SMS_MODE_THRU:
                begin
                    if (width_20)
                    begin
                        par_data_o  <= din_i;
                        par_valid_o <= 1'b1;
                    end
                    else if (!phase)
                        par_data_o[sms_pkg::HALF_W-1:0] <= upper_half(din_i);
                    else
                    begin
                        par_data_o[sms_pkg::DATA_W-1:sms_pkg::HALF_W] <= upper_half(din_i);
                        par_valid_o <= 1'b1;
                    end
                end
                default:
                    par_valid_o <= 1'b0;
            endcase
        end
    end

    // Two-word history of the upper half for marker search
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hist0 <= '0;
            hist1 <= '0;
        end
        else
        begin
            hist0 <= upper_half(din_i);
            hist1 <= hist0;
        end
    end

    // Compliance markers per mode
    always_comb
    begin
        case (mode)
            sms_pkg::SMS_MODE_VIDEO:
                mark = (hist1 == sms_pkg::TRS_ONES) && (hist0 == sms_pkg::TRS_ZERO)
                       && (upper_half(din_i) == sms_pkg::TRS_ZERO);
            sms_pkg::SMS_MODE_ASI:
                mark = (upper_half(din_i) == sms_pkg::COMMA_NEG)
                       || (upper_half(din_i) == sms_pkg::COMMA_POS);
            sms_pkg::SMS_MODE_THRU:
                mark = 1'b1;
            default:
                mark = 1'b0;
        endcase
    end

    assign det_clear = mode_chg || (mode == sms_pkg::SMS_MODE_NONE) || !ctrl[sms_pkg::CTRL_DET_EN];

    sms_lock_det #(
        .HITS    (LOCK_HITS),
        .TIMEOUT (LOCK_TIMEOUT)
    ) u_lock (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (det_clear),
        .mark_i   (mark),
        .locked_o (det_locked)
    );

    assign locked_o = det_locked;

    // Lock edge tracking for interrupts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            locked_d <= 1'b0;
        else
            locked_d <= det_locked;
    end

    assign irq_evt[sms_pkg::IRQ_LOCK_GAIN] = det_locked && !locked_d;
    assign irq_evt[sms_pkg::IRQ_LOCK_LOSS] = !det_locked && locked_d;
    assign irq_evt[sms_pkg::IRQ_MODE_CHG]  = mode_chg;

    // Control register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl <= sms_pkg::CTRL_RESET;
        else if (reg_wr_i && reg_addr_i == sms_pkg::ADDR_CTRL)
            ctrl <= {31'h0, reg_wdata_i[sms_pkg::CTRL_DET_EN]};
    end

    // Interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask <= '0;
        else if (reg_wr_i && reg_addr_i == sms_pkg::ADDR_IRQ_MASK)
            irq_mask <= reg_wdata_i[sms_pkg::IRQ_W-1:0];
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat <= '0;
        else if (reg_wr_i && reg_addr_i == sms_pkg::ADDR_IRQ_STAT)
            irq_stat <= (irq_stat & ~reg_wdata_i[sms_pkg::IRQ_W-1:0]) | irq_evt;
        else
            irq_stat <= irq_stat | irq_evt;
    end

    assign irq_o = |(irq_stat & irq_mask);

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !reg_rd_i)
            reg_rdata_o <= '0;
        else
        begin
            case (reg_addr_i)
                sms_pkg::ADDR_CTRL:     reg_rdata_o <= ctrl;
                sms_pkg::ADDR_STATUS:   reg_rdata_o <= {25'h0, mode, sd_rate, width_20, det_locked};
                sms_pkg::ADDR_IRQ_STAT: reg_rdata_o <= {29'h0, irq_stat};
                sms_pkg::ADDR_IRQ_MASK: reg_rdata_o <= {29'h0, irq_mask};
                default:                reg_rdata_o <= '0;
            endcase
        end
    end

    // Async mode only from its exact select pattern, three edges earlier
    chk_asi_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == sms_pkg::SMS_MODE_ASI) |->
            $past(async_serial_mode_select_i, 3) && $past(line_rate_select_i, 3)
            && !$past(video_processing_select_i, 3))
        else $error("async mode without its select pattern");

    // No async encoding while the async select was low
    chk_asi_encode_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(async_serial_mode_select_i, 3) |-> !asi_encode_en_o)
        else $error("async encoding with select low");

    // Encoder enable agrees with the mode register
    chk_asi_encode_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        asi_encode_en_o == (mode == sms_pkg::SMS_MODE_ASI))
        else $error("async encode enable disagrees with mode");

    // Lock rises only within a defined mode, on a marker with the detector enabled
    chk_lock_in_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(locked_o) |-> (mode != sms_pkg::SMS_MODE_NONE) && $past(mark) && $past(ctrl[sms_pkg::CTRL_DET_EN]))
        else $error("lock rose without a marker in a mode");

    // Lock falls the edge after a mode change
    chk_lock_mode_chg: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_chg |=> !locked_o)
        else $error("lock held across mode change");

    // HD rate while the rate select was low
    chk_hd_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(line_rate_select_i, 3) |-> serial_rate_kbps_o == sms_pkg::HD_RATE_KBPS)
        else $error("HD rate not selected");

    // SD rate while the rate select was high
    chk_sd_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
            && $past(line_rate_select_i, 3) |-> serial_rate_kbps_o == sms_pkg::SD_RATE_KBPS)
        else $error("SD rate not selected");

    // Async mode carries one 10-bit word per cycle, width ignored
    chk_width_asi: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(mode == sms_pkg::SMS_MODE_ASI) |->
            par_valid_o && par_data_o == {{sms_pkg::HALF_W{1'b0}}, $past(din_i[19:10])})
        else $error("async word not passed through");

    // Wide input passes whole words each cycle
    chk_width_20: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(width_20 && (mode == sms_pkg::SMS_MODE_VIDEO || mode == sms_pkg::SMS_MODE_THRU))
            |-> par_valid_o && par_data_o == $past(din_i))
        else $error("20-bit word not passed");

    // Narrow input pairs two words, never valid twice in a row
    chk_width_10: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(!width_20 && !mode_chg && (mode == sms_pkg::SMS_MODE_VIDEO || mode == sms_pkg::SMS_MODE_THRU), 2)
            && $past(!width_20 && !mode_chg && (mode == sms_pkg::SMS_MODE_VIDEO || mode == sms_pkg::SMS_MODE_THRU))
            |-> par_valid_o != $past(par_valid_o))
        else $error("10-bit pairing broken");

    // Video mode from video select high and async select low
    chk_video_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
            && $past(video_processing_select_i && !async_serial_mode_select_i, 3)
            |-> mode == sms_pkg::SMS_MODE_VIDEO)
        else $error("video mode not selected");

    // Data-through mode from both selects low
    chk_thru_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
            && $past(!video_processing_select_i && !async_serial_mode_select_i, 3)
            |-> mode == sms_pkg::SMS_MODE_THRU)
        else $error("data-through mode not selected");

    // Decoder sees each select exactly two edges after it is sampled
    chk_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> sel == $past(sel_raw, 2))
        else $error("select not passed through two sync stages");

endmodule : sms_top

// ===== testbench/sms_source.sv
// Upstream source model: drives the parallel bus with sync markers or data.
// Assumes the bench supplies the parallel clock and a fresh data word each cycle.
`timescale 1ns/1ps
module sms_source (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Control: 1 video sync, 2 async comma, else plain data
    input  wire logic [1:0]  kind_i,
    input  wire logic [19:0] data_i,
    // Parallel bus
    output logic      [19:0] din_o
);
    logic [1:0] step;

    // Bus starts defined before the first edge
    initial din_o = 20'h0;

    // Marker sequencer, one word per parallel clock
    always @(posedge clk_i)
    begin
        step <= rst_i ? 2'h0 : step + 2'h1;
        case (kind_i)
            2'h1:    din_o <= {(step == 2'h0) ? sms_pkg::TRS_ONES :
                               (step == 2'h3) ? 10'h200 : sms_pkg::TRS_ZERO, data_i[9:0]};
            2'h2:    din_o <= {step[0] ? sms_pkg::COMMA_NEG : sms_pkg::COMMA_POS, data_i[9:0]};
            default: din_o <= data_i;
        endcase
    end
endmodule : sms_source

// ===== testbench/tb_sms_top.sv
// Bench for the mode select and lock block: selects, data path, lock, registers.
// Assumes the source model feeds the bus and the bench owns selects and registers.
`timescale 1ns/1ps
module tb_sms_top;
    localparam int TOUT = 64;
    logic        clk_i, rst_i, a, r, w, v, reg_wr_i, reg_rd_i, chk_on, pv, asi, w20, sd, lk, irq;
    logic [3:0]  reg_addr_i, mode, em;
    logic [1:0]  kind;
    logic [19:0] rnd, din, h1, h2, pd;
    logic [20:0] rate;
    logic [31:0] reg_wdata_i, reg_rdata_o, seed;
    logic [3:0]  tsel [6] = '{4'h3, 4'h1, 4'h2, 4'hc, 4'h8, 4'hd};
    logic [1:0]  tknd [6] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2};
    int          fails, total_checks, nv;

    sms_top #(.LOCK_HITS(sms_pkg::LOCK_HITS), .LOCK_TIMEOUT(TOUT)) u_sms_top (
        .clk_i(clk_i), .rst_i(rst_i), .async_serial_mode_select_i(a), .line_rate_select_i(r),
        .bus_width_select_i(w), .video_processing_select_i(v), .din_i(din), .par_data_o(pd),
        .par_valid_o(pv), .mode_o(mode), .asi_encode_en_o(asi), .width_20_o(w20), .sd_rate_o(sd),
        .serial_rate_kbps_o(rate), .locked_o(lk), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq));
    sms_source u_sms_source (.clk_i(clk_i), .rst_i(rst_i), .kind_i(kind), .data_i(rnd), .din_o(din));

    // Parallel clock, one rate for all modes
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Xorshift step for the source data
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // Expected mode from the four selects {a, r, w, v}
    function automatic logic [3:0] emode(input logic [3:0] s);
        if (s[3])
            return (s[2] && !s[0]) ? 4'(sms_pkg::SMS_MODE_ASI) : 4'(sms_pkg::SMS_MODE_NONE);
        return s[0] ? 4'(sms_pkg::SMS_MODE_VIDEO) : 4'(sms_pkg::SMS_MODE_THRU);
    endfunction : emode

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Random word every cycle; word assembly reference on each valid word
    always @(posedge clk_i)
    begin
        seed <= xs(seed);
        rnd  <= seed[19:0];
        h1   <= din;
        h2   <= h1;
        if (chk_on && pv === 1'b1)
        begin
            nv++;
            chk(32'(pd), (em == 4'(sms_pkg::SMS_MODE_ASI)) ? {22'h0, h1[19:10]} :
                w ? 32'(h1) : {12'h0, h1[19:10], h2[19:10]});
        end
    end

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i  <= ad;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(reg_rdata_o & m, e);
    endtask : rdc

    // Apply selects and source kind, wait out sync and decode
    task automatic sel(input logic [3:0] s, input logic [1:0] k);
        @(posedge clk_i);
        {a, r, w, v} <= s;
        kind         <= k;
        em = emode(s);
        repeat (4) @(posedge clk_i);
        #1;
    endtask : sel

    // Bounded wait for the lock level
    task automatic wait_lk(input logic e, input int b);
        int n;
        n = 0;
        while (lk !== e && n < b)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(32'(lk), 32'(e));
        if (lk !== e)
            stop_test();
    endtask : wait_lk

    initial
    begin
        {rst_i, a, r, w, v, kind, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
        rst_i = 1'b1;
        seed = 32'd51;
        {rnd, chk_on, fails, total_checks, nv} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk(32'(mode), 32'(sms_pkg::SMS_MODE_NONE));
        chk({lk, irq, asi}, 3'h0);
        rdc(sms_pkg::ADDR_CTRL, 32'hffffffff, sms_pkg::CTRL_RESET);
        // Every select combination
        for (int i = 0; i < 16; i++)
        begin
            sel(i[3:0], 2'h0);
            chk(32'(mode), 32'(em));
            chk(32'(asi), 32'(em == 4'(sms_pkg::SMS_MODE_ASI)));
            chk(32'(rate), 32'(r ? sms_pkg::SD_RATE_KBPS : sms_pkg::HD_RATE_KBPS));
            chk({w20, sd}, {w, r});
        end
        // Lock, data path and status per mode
        for (int i = 0; i < 6; i++)
        begin
            sel(tsel[i], tknd[i]);
            wait_lk(em != 4'(sms_pkg::SMS_MODE_NONE), (em != 4'(sms_pkg::SMS_MODE_NONE)) ? 200 : 1);
            nv = 0;
            chk_on <= 1'b1;
            repeat (40) @(posedge clk_i);
            chk_on <= 1'b0;
            #1 chk(32'(lk), 32'(em != 4'(sms_pkg::SMS_MODE_NONE)));
            chk(32'(nv != 0), 32'(em != 4'(sms_pkg::SMS_MODE_NONE)));
            rdc(sms_pkg::ADDR_STATUS, 32'h7f, {25'h0, em, r, w, lk});
        end
        // Interrupt set, masked, unmasked and cleared
        wr(sms_pkg::ADDR_IRQ_STAT, 32'h7);
        rdc(sms_pkg::ADDR_IRQ_STAT, 32'h7, 32'h0);
        sel(4'h2, 2'h0);
        chk(32'(irq), 32'h0);
        rdc(sms_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
        rdc(4'h2, 32'hffffffff, 32'h0);
        wr(sms_pkg::ADDR_IRQ_MASK, 32'h4);
        #1 chk(32'(irq), 32'h1);
        wr(sms_pkg::ADDR_IRQ_STAT, 32'h4);
        #1 chk(32'(irq), 32'h0);
        // Detector disable drops lock, enable regains it
        wait_lk(1'b1, 20);
        wr(sms_pkg::ADDR_CTRL, 32'h0);
        wait_lk(1'b0, 5);
        wr(sms_pkg::ADDR_CTRL, 32'h1);
        wait_lk(1'b1, 20);
        // Markers stop in video mode: lock lost after the silent gap
        sel(4'h3, 2'h1);
        wait_lk(1'b1, 200);
        wr(sms_pkg::ADDR_IRQ_STAT, 32'h2);
        kind <= 2'h0;
        wait_lk(1'b0, 2 * TOUT + 20);
        rdc(sms_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
        stop_test();
    end
endmodule : tb_sms_top
